// ---- plgau_pkg.sv ----
// plgau_pkg: register map, field positions and constants for the pid loop unit
// assumes a single 40 MHz clock domain and an AHB-Lite register port
package plgau_pkg;
	localparam logic [7:0] OFS_CFG1 = 8'h00;
	localparam logic [7:0] OFS_SETPOINT = 8'h04;
	localparam logic [7:0] OFS_PROCVAR = 8'h08;
	localparam logic [7:0] OFS_GAIN_P = 8'h0C;
	localparam logic [7:0] OFS_GAIN_I = 8'h10;
	localparam logic [7:0] OFS_GAIN_D = 8'h14;
	localparam logic [7:0] OFS_OUT_HI = 8'h18;
	localparam logic [7:0] OFS_OUT_LO = 8'h1C;
	localparam logic [7:0] OFS_ALM_HH = 8'h20;
	localparam logic [7:0] OFS_ALM_H = 8'h24;
	localparam logic [7:0] OFS_ALM_L = 8'h28;
	localparam logic [7:0] OFS_ALM_LL = 8'h2C;
	localparam logic [7:0] OFS_HYST = 8'h30;
	localparam logic [7:0] OFS_DEADBAND = 8'h34;
	localparam logic [7:0] OFS_DLIMIT = 8'h38;
	localparam logic [7:0] OFS_OUTPUT = 8'h3C;
	localparam logic [7:0] OFS_STATUS = 8'h40;
	localparam logic [7:0] OFS_BIAS = 8'h44;
	// loop_config_word_one bit positions
	localparam int CFG_MIN_UNIT = 0;
	localparam int CFG_FMT15 = 1;
	localparam int CFG_SQUARE = 2;
	localparam int CFG_DEADBAND = 3;
	localparam int CFG_DLIM_EN = 4;
	localparam int CFG_FREEZE = 10;
	localparam int CFG_LIMIT_ALM = 12;
	// loop_alarm_status_word bit positions
	localparam int ST_HH = 8;
	localparam int ST_H = 9;
	localparam int ST_L = 10;
	localparam int ST_LL = 11;
	localparam int ST_APE = 12;
	localparam int ST_BUSY = 0;
	localparam logic [15:0] RST_OUT_HI = 16'h0FFF;
	localparam logic [15:0] RST_HYST = 16'h0001;
	localparam logic [15:0] RANGE12 = 16'h0FFF;
	localparam logic [15:0] RANGE15 = 16'h7FFF;
	localparam logic [15:0] BCD_INF = 16'h9999;
	localparam logic [15:0] HYST_MAX = 16'h00C8;
	localparam logic [15:0] DLIM_MAX = 16'h0014;
	localparam int SEC_PER_MIN = 60;
	typedef enum logic [1:0] {PL_IDLE = 2'b00, PL_TERMS = 2'b01, PL_SUM = 2'b11, PL_DONE = 2'b10} plgau_state_e;
endpackage

// ---- plgau_top.sv ----
// plgau_top: pid calculation unit with absolute-limit process-variable alarms
// assumes a sample strobe from the scan logic on hclk and an AHB-Lite master
// Functional notes
// - output never exceeds upper limit; zero upper limit keeps output zero
// - output is sum of p, i, d terms fed the same error
// - gains are four-digit bcd with two implied fractional digits
// - proportional gain 0000 removes the proportional term
// - integral setting 0000 or 9999 removes the integral term
// - integral unit seconds or minutes; derivative seconds; proportional unitless
// - derivative setting 0000 removes the derivative term
// - optional derivative limit, value 0 to 20 supplied by software
// - error recomputed each calculation as setpoint minus process variable, not readable
// - error squaring keeps the original sign
// - deadband replaces small errors with zero, larger pass unchanged
// - freeze-bias bit 10 holds integral bias while output at range end
// - freeze triggers only at full data range ends, not user limits
// - four absolute thresholds; none set between upper and lower
// - thresholds compared in the process-variable format, 12 or 15 bit
// - limit alarms monitored only when limit-alarm option is on
// - four alarm states are individual bits of the status word
// - programming error flag unless low-low < low < high < high-high
// - alarms set on crossing, clear after hysteresis 1 to 200 counts
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
module plgau_top import plgau_pkg::*; #(
	parameter int SAMPLE_MS = 50
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// loop
	input wire logic sample_stb,
	output logic [15:0] control_output,
	output logic [3:0] alarm_bits,
	output logic calc_done
);
	logic [15:0] cfg_r, cfg_nxt, sp_r, sp_nxt, pv_r, pv_nxt;
	logic [15:0] kp_r, kp_nxt, ki_r, ki_nxt, kd_r, kd_nxt;
	logic [15:0] ohi_r, ohi_nxt, olo_r, olo_nxt;
	logic [15:0] thh_r, thh_nxt, th_r, th_nxt, tl_r, tl_nxt, tll_r, tll_nxt;
	logic [15:0] hys_r, hys_nxt, db_r, db_nxt, dl_r, dl_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_nxt;
	plgau_state_e st_r, st_nxt;
	logic signed [31:0] err_r, err_nxt, perr_r, perr_nxt, bias_r, bias_nxt;
	logic signed [31:0] pt_r, pt_nxt, dt_r, dt_nxt;
	logic [15:0] out_r, out_nxt;
	logic [3:0] alm_r, alm_nxt;
	logic ape_r, ape_nxt, done_nxt;
	logic [15:0] range_max;
	logic signed [31:0] raw_err, sq_err, abs_err, sum;
	logic [15:0] kp_bin, ki_bin, kd_bin;
	// signed copies: an unsigned operand would turn negative errors into huge positives
	logic signed [31:0] kp_s, ki_s, kd_s, dl_s, ohi_s, olo_s;

	// bcd to binary, value in hundredths
	function automatic logic [15:0] bcd2bin(input logic [15:0] b);
		bcd2bin = 16'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
	endfunction

	assign range_max = cfg_r[CFG_FMT15] ? RANGE15 : RANGE12;
	assign kp_bin = bcd2bin(kp_r);
	assign ki_bin = bcd2bin(ki_r);
	assign kd_bin = bcd2bin(kd_r);
	assign kp_s = signed'({16'h0000, kp_bin});
	assign ki_s = signed'({16'h0000, ki_bin});
	assign kd_s = signed'({16'h0000, kd_bin});
	assign dl_s = signed'({16'h0000, dl_r});
	assign ohi_s = signed'({16'h0000, ohi_r});
	assign olo_s = signed'({16'h0000, olo_r});

	// register bus: writes land one cycle after the address phase, zero wait states
	always_comb begin
		wr_pend_nxt = hsel && hready && htrans[1] && hwrite;
		wr_addr_nxt = haddr[7:0];
		{cfg_nxt, sp_nxt, pv_nxt, kp_nxt, ki_nxt, kd_nxt} = {cfg_r, sp_r, pv_r, kp_r, ki_r, kd_r};
		{ohi_nxt, olo_nxt, thh_nxt, th_nxt, tl_nxt, tll_nxt} = {ohi_r, olo_r, thh_r, th_r, tl_r, tll_r};
		{hys_nxt, db_nxt, dl_nxt} = {hys_r, db_r, dl_r};
		hrdata_nxt = 32'h00000000;
		if (wr_pend_r) begin
			case (wr_addr_r)
				OFS_CFG1: cfg_nxt = hwdata[15:0];
				OFS_SETPOINT: sp_nxt = hwdata[15:0];
				OFS_PROCVAR: pv_nxt = hwdata[15:0];
				OFS_GAIN_P: kp_nxt = hwdata[15:0];
				OFS_GAIN_I: ki_nxt = hwdata[15:0];
				OFS_GAIN_D: kd_nxt = hwdata[15:0];
				OFS_OUT_HI: ohi_nxt = hwdata[15:0];
				OFS_OUT_LO: olo_nxt = hwdata[15:0];
				OFS_ALM_HH: thh_nxt = hwdata[15:0];
				OFS_ALM_H: th_nxt = hwdata[15:0];
				OFS_ALM_L: tl_nxt = hwdata[15:0];
				OFS_ALM_LL: tll_nxt = hwdata[15:0];
				OFS_HYST: hys_nxt = (hwdata[15:0] == 16'h0000) ? RST_HYST :
					(hwdata[15:0] > HYST_MAX) ? HYST_MAX : hwdata[15:0];
				OFS_DEADBAND: db_nxt = hwdata[15:0];
				OFS_DLIMIT: dl_nxt = (hwdata[15:0] > DLIM_MAX) ? DLIM_MAX : hwdata[15:0];
				default: ;
			endcase
		end
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFS_CFG1: hrdata_nxt = {16'h0000, cfg_r};
				OFS_SETPOINT: hrdata_nxt = {16'h0000, sp_r};
				OFS_PROCVAR: hrdata_nxt = {16'h0000, pv_r};
				OFS_GAIN_P: hrdata_nxt = {16'h0000, kp_r};
				OFS_GAIN_I: hrdata_nxt = {16'h0000, ki_r};
				OFS_GAIN_D: hrdata_nxt = {16'h0000, kd_r};
				OFS_OUT_HI: hrdata_nxt = {16'h0000, ohi_r};
				OFS_OUT_LO: hrdata_nxt = {16'h0000, olo_r};
				OFS_ALM_HH: hrdata_nxt = {16'h0000, thh_r};
				OFS_ALM_H: hrdata_nxt = {16'h0000, th_r};
				OFS_ALM_L: hrdata_nxt = {16'h0000, tl_r};
				OFS_ALM_LL: hrdata_nxt = {16'h0000, tll_r};
				OFS_HYST: hrdata_nxt = {16'h0000, hys_r};
				OFS_DEADBAND: hrdata_nxt = {16'h0000, db_r};
				OFS_DLIMIT: hrdata_nxt = {16'h0000, dl_r};
				OFS_OUTPUT: hrdata_nxt = {16'h0000, out_r};
				// alarm bits in the status word
				OFS_STATUS: hrdata_nxt = {19'h00000, ape_r, alm_r[0], alm_r[1], alm_r[2], alm_r[3],
					7'h00, st_r != PL_IDLE};
				OFS_BIAS: hrdata_nxt = bias_r;
				default: hrdata_nxt = 32'h00000000;
			endcase
		end
	end

	// error formed fresh from the current setpoint and process variable
	assign raw_err = 32'(signed'({16'h0000, sp_r})) - 32'(signed'({16'h0000, pv_r}));
	assign abs_err = raw_err[31] ? -raw_err : raw_err;
	// square scaled back to range, sign kept
	assign sq_err = raw_err[31] ? -((abs_err * abs_err) / 32'(range_max)) : (abs_err * abs_err) / 32'(range_max);

	// one shared error, three terms summed
	assign sum = pt_r + bias_r + dt_r;

	always_comb begin
		st_nxt = st_r;
		err_nxt = err_r;
		perr_nxt = perr_r;
		bias_nxt = bias_r;
		pt_nxt = pt_r;
		dt_nxt = dt_r;
		out_nxt = out_r;
		alm_nxt = alm_r;
		ape_nxt = ape_r;
		done_nxt = 1'b0;
		case (st_r)
			PL_IDLE: begin
				if (sample_stb) begin
					if (cfg_r[CFG_DEADBAND] && abs_err <= 32'(db_r))
						err_nxt = 32'sh0;
					else if (cfg_r[CFG_SQUARE])
						err_nxt = sq_err;
					else
						err_nxt = raw_err;
					st_nxt = PL_TERMS;
				end
			end
			PL_TERMS: begin
				// zero proportional gain yields zero term
				pt_nxt = (kp_s * err_r) / 100;
				// derivative off at 0000; limit bounds the rate gain
				if (kd_bin == 16'h0000)
					dt_nxt = 32'sh0;
				else if (cfg_r[CFG_DLIM_EN] && 32'(kd_bin) > 32'(dl_r) * 100)
					dt_nxt = (dl_s * (err_r - perr_r) * 1000) / SAMPLE_MS;
				else
					dt_nxt = (kd_s * (err_r - perr_r) * 10) / SAMPLE_MS;
				// freeze only at full range ends
				if (cfg_r[CFG_FREEZE] && (out_r == 16'h0000 || out_r == range_max))
					bias_nxt = bias_r;
				// infinite integral time removes the integrator
				else if (ki_r == 16'h0000 || ki_r == BCD_INF)
					bias_nxt = 32'sh0;
				// integral time in seconds or minutes
				else if (cfg_r[CFG_MIN_UNIT])
					bias_nxt = bias_r + (err_r * SAMPLE_MS) / (ki_s * 10 * SEC_PER_MIN);
				else
					bias_nxt = bias_r + (err_r * SAMPLE_MS) / (ki_s * 10);
				perr_nxt = err_r;
				st_nxt = PL_SUM;
			end
			PL_SUM: begin
				// upper clamp, zero limit gives zero output
				if (sum >= ohi_s || ohi_r == 16'h0000)
					out_nxt = ohi_r;
				else if (sum <= olo_s)
					out_nxt = olo_r;
				else
					out_nxt = sum[15:0];
				if (ohi_r < olo_r)
					out_nxt = ohi_r;
				ape_nxt = !(tll_r < tl_r && tl_r < th_r && th_r < thh_r);
				// set on crossing, clear past hysteresis
				if (!cfg_r[CFG_LIMIT_ALM])
					alm_nxt = 4'h0;
				else begin
					alm_nxt[3] = (pv_r >= thh_r) || (alm_r[3] && 17'(pv_r) + 17'(hys_r) > 17'(thh_r));
					alm_nxt[2] = (pv_r >= th_r) || (alm_r[2] && 17'(pv_r) + 17'(hys_r) > 17'(th_r));
					alm_nxt[1] = (pv_r <= tl_r) || (alm_r[1] && 17'(pv_r) < 17'(tl_r) + 17'(hys_r));
					alm_nxt[0] = (pv_r <= tll_r) || (alm_r[0] && 17'(pv_r) < 17'(tll_r) + 17'(hys_r));
				end
				st_nxt = PL_DONE;
			end
			PL_DONE: begin
				done_nxt = 1'b1;
				st_nxt = PL_IDLE;
			end
			default: st_nxt = PL_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{cfg_r, sp_r, pv_r, kp_r, ki_r, kd_r} <= '0;
			ohi_r <= RST_OUT_HI;
			{olo_r, thh_r, th_r, tl_r, tll_r, db_r, dl_r} <= '0;
			hys_r <= RST_HYST;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
			st_r <= PL_IDLE;
			{err_r, perr_r, bias_r, pt_r, dt_r} <= '0;
			out_r <= 16'h0000;
			alm_r <= 4'h0;
			ape_r <= 1'b0;
		end else if (clk_en) begin
			{cfg_r, sp_r, pv_r, kp_r, ki_r, kd_r} <= {cfg_nxt, sp_nxt, pv_nxt, kp_nxt, ki_nxt, kd_nxt};
			{ohi_r, olo_r, thh_r, th_r, tl_r, tll_r} <= {ohi_nxt, olo_nxt, thh_nxt, th_nxt, tl_nxt, tll_nxt};
			{hys_r, db_r, dl_r} <= {hys_nxt, db_nxt, dl_nxt};
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata <= hrdata_nxt;
			st_r <= st_nxt;
			{err_r, perr_r, bias_r, pt_r, dt_r} <= {err_nxt, perr_nxt, bias_nxt, pt_nxt, dt_nxt};
			out_r <= out_nxt;
			alm_r <= alm_nxt;
			ape_r <= ape_nxt;
		end
	end

	// registered copies for the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_output <= 16'h0000;
			alarm_bits <= 4'h0;
			calc_done <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			control_output <= out_r;
			alarm_bits <= alm_r;
			calc_done <= done_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule

// ---- plgau_sva.sv ----
// plgau_sva: port-level timing checks for the pid loop unit
// assumes one hclk domain, async active-low reset and clk_en held high
module plgau_sva (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// loop
	input wire logic sample_stb,
	input wire logic [15:0] control_output,
	input wire logic [3:0] alarm_bits,
	input wire logic calc_done
);
	logic rd_r;
	logic rd_nxt;
	always_comb begin
		rd_nxt = hsel && hready && htrans[1] && !hwrite;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_r <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	zero_wait_a: assert property (hreadyout) else $error("hreadyout low");
	okay_resp_a: assert property (!hresp) else $error("hresp not okay");
	idle_rdata_a: assert property (!rd_r |-> hrdata == 32'h0) else $error("hrdata not zero outside read");
	calc_latency_a: assert property (calc_done |-> $past(sample_stb, 4)) else $error("calc_done without strobe");
	done_pulse_a: assert property (calc_done |=> !calc_done [*3]) else $error("calc_done too close");
	out_hold_a: assert property (!calc_done |-> $stable(control_output)) else $error("output moved");
	alarm_hold_a: assert property (!calc_done |-> $stable(alarm_bits)) else $error("alarms moved");
	idle_take_a: assert property (calc_done ##1 sample_stb |-> ##4 calc_done) else $error("strobe not taken");
endmodule

bind plgau_top plgau_sva i_plgau_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_stb(sample_stb),
	.control_output(control_output), .alarm_bits(alarm_bits), .calc_done(calc_done));

// ---- plgau_top_tb.sv ----
// plgau_top_tb: register-level tests of the pid loop unit
// assumes a zero-wait ahb-lite slave; gains of 1.00 give unit error gain
module plgau_top_tb import plgau_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, sample_stb, calc_done, hresp, hreadyout;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] control_output;
	logic [3:0] alarm_bits;
	int err_count = 0;
	int checked = 0;
	plgau_top #(.SAMPLE_MS(50)) i_plgau_top (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_stb(sample_stb),
		.control_output(control_output), .alarm_bits(alarm_bits), .calc_done(calc_done));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic wrap_up;
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait: a hang is counted and ends the run
	task automatic wait_hi(input bit on_done);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		do begin
			@(posedge hclk);
			n++;
			s = on_done ? calc_done : hreadyout;
		end while (s !== 1'b1 && n < 40);
		if (s !== 1'b1) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_hi(1'b0);
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(1'b0);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic pulse(input logic [15:0] out, input logic [3:0] alm);
		sample_stb <= 1'b1;
		@(posedge hclk);
		sample_stb <= 1'b0;
		wait_hi(1'b1);
		chk({16'h0, control_output}, {16'h0, out});
		chk({28'h0, alarm_bits}, {28'h0, alm});
	endtask
	task automatic calc(input logic [15:0] pv, input logic [15:0] out, input logic [3:0] alm);
		wr(OFS_PROCVAR, {16'h0, pv});
		pulse(out, alm);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		sample_stb = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(OFS_OUT_HI, 32'h0FFF);
		rdc(OFS_HYST, 32'h1);
		wr(8'h80, 32'h1234);
		rdc(8'h80, 32'h0);
		wr(OFS_ALM_LL, 32'h100);
		wr(OFS_ALM_L, 32'h200);
		wr(OFS_ALM_H, 32'h800);
		wr(OFS_ALM_HH, 32'h900);
		wr(OFS_HYST, 32'h10);
		wr(OFS_SETPOINT, 32'h400);
		wr(OFS_GAIN_P, 32'h0100);
		wr(OFS_CFG1, 32'h1000);
		calc(16'h0300, 16'h0100, 4'h0);
		calc(16'h0850, 16'h0000, 4'h4);
		rdc(OFS_STATUS, 32'h0200);
		calc(16'h07F8, 16'h0000, 4'h4);
		calc(16'h07EF, 16'h0000, 4'h0);
		calc(16'h0950, 16'h0000, 4'hC);
		calc(16'h0050, 16'h03B0, 4'h3);
		wr(OFS_GAIN_P, 32'h0);
		wr(OFS_OUT_LO, 32'h20);
		calc(16'h0050, 16'h0020, 4'h3);
		wr(OFS_GAIN_P, 32'h9999);
		wr(OFS_OUT_HI, 32'h0);
		calc(16'h0050, 16'h0000, 4'h3);
		wr(OFS_OUT_HI, 32'h0FFF);
		wr(OFS_OUT_LO, 32'h0);
		wr(OFS_GAIN_P, 32'h0100);
		wr(OFS_DEADBAND, 32'h10);
		wr(OFS_CFG1, 32'h1008);
		calc(16'h03F0, 16'h0000, 4'h0);
		calc(16'h03E0, 16'h0020, 4'h0);
		wr(OFS_CFG1, 32'h0);
		calc(16'h0950, 16'h0000, 4'h0);
		wr(OFS_CFG1, 32'h1000);
		wr(OFS_ALM_HH, 32'h0700);
		calc(16'h0400, 16'h0000, 4'h0);
		rdc(OFS_STATUS, 32'h1000);
		wr(OFS_DLIMIT, 32'h000A);
		rdc(OFS_DLIMIT, 32'h000A);
		wr(OFS_CFG1, 32'h1004);
		calc(16'h03C0, 16'h0001, 4'h0);
		wr(OFS_CFG1, 32'h1000);
		wr(OFS_GAIN_P, 32'h0);
		wr(OFS_GAIN_I, 32'h0100);
		calc(16'h0180, 16'h0020, 4'h2);
		pulse(16'h0040, 4'h2);
		wr(OFS_GAIN_I, 32'h9999);
		calc(16'h0180, 16'h0000, 4'h2);
		wrap_up();
	end
endmodule
